// ==== design/eca_pkg.sv ====
// Shared constants and types for the EEPROM configuration access block.
package eca_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] ADDR_CTRL = 8'hc8;
  localparam logic [7:0] ADDR_TEST = 8'hcc;
  localparam logic [7:0] ADDR_INT_STAT = 8'hd0;
  localparam logic [7:0] ADDR_INT_MASK = 8'hd4;
  localparam logic [7:0] ADDR_IDENT = 8'hf0;

  // Field positions in the cycle control word.
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_CMD_BIT = 1;
  localparam int CTRL_ERR_BIT = 2;
  localparam int CTRL_ALOK_BIT = 3;
  localparam int CTRL_RATE_LSB = 6;
  localparam int CTRL_ADDR_LSB = 8;
  localparam int CTRL_DATA_LSB = 16;

  // Field positions in the strap and test word.
  localparam int TEST_LSB_BIT = 29;
  localparam int TEST_SLOW_BIT = 28;
  localparam int TEST_NOBYP_BIT = 27;
  localparam int TEST_ALOK_BIT = 26;
  localparam int TEST_ALDIS_BIT = 24;

  // Interrupt status and mask bit positions.
  localparam int INT_DONE_BIT = 0;
  localparam int INT_ERR_BIT = 1;
  localparam int INT_AL_BIT = 2;
  localparam int INT_WIDTH = 3;

  // Clock rate codes and the divisors they select.
  localparam logic [1:0] RATE_SLOW = 2'h1;
  localparam logic [1:0] RATE_FAST = 2'h2;
  localparam logic [8:0] DIV_SLOW = 9'h100;
  localparam logic [8:0] DIV_FAST = 9'h080;

  // Serial frame lengths in bits.
  localparam logic [4:0] HDR_BITS = 5'h0a;
  localparam logic [4:0] WR_BITS = 5'h1a;
  localparam logic [4:0] RD_BITS = 5'h10;

  // Word addresses read by autoload.
  localparam logic [7:0] AL_VEN_ADDR = 8'h00;
  localparam logic [7:0] AL_PRD_ADDR = 8'h01;

  // Reset values.
  localparam logic [1:0] RATE_RST = 2'h1;
  localparam logic [INT_WIDTH-1:0] INT_RST = 3'h0;

  typedef enum logic [4:0] {
    ST_STRAP = 5'b00001,
    ST_LOAD = 5'b00010,
    ST_WAIT = 5'b00100,
    ST_READY = 5'b01000,
    ST_BUSY = 5'b10000
  } eca_state_type;

  typedef enum logic [3:0] {
    PH_IDLE = 4'b0001,
    PH_OUT = 4'b0010,
    PH_ACK = 4'b0100,
    PH_IN = 4'b1000
  } eca_phase_type;

endpackage

// ==== design/eca_ser_if.sv ====
// Request and answer signals between the controller and the serial engine.
`timescale 1ns/100ps
`default_nettype none
interface eca_ser_if;
  logic req;
  logic cmd;
  logic fast;
  logic lsb_first;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic done;
  logic ack_err;
  logic [15:0] rdata;

  modport ctrl (
    output req,
    output cmd,
    output fast,
    output lsb_first,
    output addr,
    output wdata,
    input done,
    input ack_err,
    input rdata
  );

  modport eng (
    input req,
    input cmd,
    input fast,
    input lsb_first,
    input addr,
    input wdata,
    output done,
    output ack_err,
    output rdata
  );
endinterface
`default_nettype wire

// ==== design/eca_serial.sv ====
// Serial engine that runs one EEPROM read or write frame.
`timescale 1ns/100ps
`default_nettype none
module eca_serial (
  input wire logic pclk,
  input wire logic presetn,
  eca_ser_if.eng ser,
  input wire logic ee_data_i,
  output logic ee_clk,
  output logic ee_data_o,
  output logic ee_data_oe
);

  eca_pkg::eca_phase_type ph_r;
  logic [8:0] cnt_r;
  logic [8:0] div_r;
  logic [4:0] bits_r;
  logic [25:0] sh_r;
  logic [15:0] rd_r;
  logic cmd_r, lsb_r, clk_r, do_r, oe_r, done_r, err_r;

  wire logic start_ok = ser.req && (ph_r == eca_pkg::PH_IDLE);
  wire logic [8:0] div_sel = ser.fast ? eca_pkg::DIV_FAST : eca_pkg::DIV_SLOW;
  wire logic cnt_mid = (cnt_r == ((div_r >> 1) - 9'h001));
  wire logic cnt_last = (cnt_r == (div_r - 9'h001));
  wire logic last_bit = (bits_r == 5'h01);
  wire logic [7:0] addr_rev = {<<{ser.addr}};
  wire logic [15:0] wd_rev = {<<{ser.wdata}};
  wire logic [7:0] addr_ord = ser.lsb_first ? addr_rev : ser.addr;
  wire logic [15:0] wd_ord = ser.lsb_first ? wd_rev : ser.wdata;
  wire logic ack_fin = (ph_r == eca_pkg::PH_ACK) && cnt_last
                       && (err_r || cmd_r);
  wire logic in_fin = (ph_r == eca_pkg::PH_IN) && cnt_last && last_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Bit timing: low for the first half of each bit, high for the second.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 9'h000;
      clk_r <= 1'b0;
    end else begin
      cnt_r <= (start_ok || cnt_last || ph_r == eca_pkg::PH_IDLE) ? 9'h000
               : cnt_r + 9'h001;
      if (ph_r != eca_pkg::PH_IDLE && cnt_mid) begin
        clk_r <= 1'b1;
      end else if (cnt_last) begin
        clk_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_r <= eca_pkg::PH_IDLE;
      div_r <= eca_pkg::DIV_SLOW;
      bits_r <= 5'h00;
      sh_r <= 26'h000_0000;
      rd_r <= 16'h0000;
      cmd_r <= 1'b0;
      lsb_r <= 1'b1;
      do_r <= 1'b0;
      oe_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      done_r <= ack_fin || in_fin;
      unique case (ph_r)
        eca_pkg::PH_IDLE: begin
          if (start_ok) begin
            ph_r <= eca_pkg::PH_OUT;
            div_r <= div_sel;
            cmd_r <= ser.cmd;
            lsb_r <= ser.lsb_first;
            sh_r <= {1'b1, ser.cmd, addr_ord, wd_ord};
            bits_r <= ser.cmd ? eca_pkg::WR_BITS : eca_pkg::HDR_BITS;
            do_r <= 1'b1;
            oe_r <= 1'b1;
            err_r <= 1'b0;
          end
        end
        eca_pkg::PH_OUT: begin
          if (cnt_last) begin
            if (last_bit) begin
              ph_r <= eca_pkg::PH_ACK;
              oe_r <= 1'b0;
            end else begin
              sh_r <= {sh_r[24:0], 1'b0};
              do_r <= sh_r[24];
              bits_r <= bits_r - 5'h01;
            end
          end
        end
        eca_pkg::PH_ACK: begin
          if (cnt_mid) begin
            err_r <= ee_data_i;
          end
          if (ack_fin) begin
            ph_r <= eca_pkg::PH_IDLE;
          end else if (cnt_last) begin
            ph_r <= eca_pkg::PH_IN;
            bits_r <= eca_pkg::RD_BITS;
          end
        end
        eca_pkg::PH_IN: begin
          if (cnt_mid) begin
            rd_r <= lsb_r ? {ee_data_i, rd_r[15:1]} : {rd_r[14:0], ee_data_i};
          end
          if (in_fin) begin
            ph_r <= eca_pkg::PH_IDLE;
          end else if (cnt_last) begin
            bits_r <= bits_r - 5'h01;
          end
        end
      endcase
    end
  end

  assign ee_clk = clk_r;
  assign ee_data_o = do_r;
  assign ee_data_oe = oe_r;
  assign ser.done = done_r;
  assign ser.ack_err = err_r;
  assign ser.rdata = rd_r;

  a_div_select: assert property (@(posedge pclk) disable iff (!presetn)
    start_ok |=> div_r == ($past(ser.fast) ? 9'h080 : 9'h100))
    else $error("serial divisor does not follow the rate select");

endmodule
`default_nettype wire

// ==== design/eca_top.sv ====
// EEPROM configuration access controller with APB registers and autoload.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none
module eca_top #(
  // Default identities; the values are arbitrary.
  parameter logic [15:0] VEN_DEFAULT = 16'h0a5a,
  parameter logic [15:0] PRD_DEFAULT = 16'h0c3c
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] strap_grant,
  input wire logic ee_data_i,
  output logic ee_clk,
  output logic ee_data_o,
  output logic ee_data_oe,
  output logic irq
);

  eca_ser_if ser ();

  eca_pkg::eca_state_type st_r;
  logic start_r, cmd_r, err_r, al_ok_r, al_dis_r, al_idx_r;
  logic lsb_r, slow_r, nobyp_r, req_r, irq_r;
  logic [1:0] rate_r;
  logic [7:0] addr_r;
  logic [15:0] data_r, ven_r, prd_r, ven_tmp_r;
  logic [eca_pkg::INT_WIDTH-1:0] int_stat_r, int_mask_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode. Every access takes one wait state.
  wire logic apb_acc = psel && penable && !pready_r;
  wire logic apb_done = psel && penable && pready_r;
  wire logic apb_wr = apb_done && pwrite;
  wire logic sel_ctrl = (paddr == eca_pkg::ADDR_CTRL);
  wire logic sel_test = (paddr == eca_pkg::ADDR_TEST);
  wire logic sel_stat = (paddr == eca_pkg::ADDR_INT_STAT);
  wire logic sel_mask = (paddr == eca_pkg::ADDR_INT_MASK);
  wire logic sel_ident = (paddr == eca_pkg::ADDR_IDENT);
  wire logic sel_any = sel_ctrl || sel_test || sel_stat || sel_mask
                       || sel_ident;

  wire logic is_ready = (st_r == eca_pkg::ST_READY);
  wire logic is_busy = (st_r == eca_pkg::ST_BUSY);
  wire logic is_wait = (st_r == eca_pkg::ST_WAIT);
  wire logic al_mode = !(is_ready || is_busy);
  // Control writes are ignored while a cycle or autoload is in flight.
  wire logic wr_ctrl = apb_wr && sel_ctrl && is_ready;
  wire logic sw_go = wr_ctrl && pwdata[eca_pkg::CTRL_START_BIT];
  wire logic sw_end = is_busy && ser.done;
  wire logic al_end = is_wait && ser.done;
  wire logic al_good = al_end && !ser.ack_err && al_idx_r;

  wire logic [31:0] rd_ctrl = {data_r, addr_r, rate_r, 2'b00, al_ok_r,
                               err_r, cmd_r, start_r};
  wire logic [31:0] rd_test = {2'b00, lsb_r, slow_r, nobyp_r, al_ok_r,
                               1'b0, al_dis_r, 24'h00_0000};
  wire logic [31:0] rd_stat = {29'h0000_0000, int_stat_r};
  wire logic [31:0] rd_mask = {29'h0000_0000, int_mask_r};
  wire logic [31:0] rd_ident = {prd_r, ven_r};
  wire logic [31:0] rd_mux = sel_ctrl ? rd_ctrl
                           : sel_test ? rd_test
                           : sel_stat ? rd_stat
                           : sel_mask ? rd_mask
                           : sel_ident ? rd_ident
                           : 32'h0000_0000;

  wire logic [eca_pkg::INT_WIDTH-1:0] int_ev = {al_end && (al_idx_r
                                                || ser.ack_err),
                                                ser.done && ser.ack_err,
                                                sw_end};
  wire logic [eca_pkg::INT_WIDTH-1:0] int_clr = (apb_wr && sel_stat)
                                     ? pwdata[eca_pkg::INT_WIDTH-1:0]
                                     : 3'h0;
  wire logic [eca_pkg::INT_WIDTH-1:0] int_stat_nxt = (int_stat_r & ~int_clr)
                                                     | int_ev;
  wire logic [eca_pkg::INT_WIDTH-1:0] int_mask_nxt = (apb_wr && sel_mask)
                                     ? pwdata[eca_pkg::INT_WIDTH-1:0]
                                     : int_mask_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= apb_acc;
      pslverr_r <= apb_acc && !sel_any;
      prdata_r <= (apb_acc && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, set wins over a write-one clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_r <= eca_pkg::INT_RST;
      int_mask_r <= eca_pkg::INT_RST;
      irq_r <= 1'b0;
    end else begin
      int_stat_r <= int_stat_nxt;
      int_mask_r <= int_mask_nxt;
      // The interrupt uses the next status and mask, so it tracks both.
      irq_r <= |(int_stat_nxt & int_mask_nxt);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Straps are caught on the first edge after reset release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lsb_r <= 1'b1;
      slow_r <= 1'b0;
      nobyp_r <= 1'b1;
    end else if (st_r == eca_pkg::ST_STRAP) begin
      lsb_r <= strap_grant[2];
      slow_r <= strap_grant[1];
      nobyp_r <= strap_grant[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer for autoload and software cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= eca_pkg::ST_STRAP;
      al_idx_r <= 1'b0;
      al_dis_r <= 1'b1;
      al_ok_r <= 1'b0;
      req_r <= 1'b0;
      ven_tmp_r <= 16'h0000;
    end else begin
      req_r <= (st_r == eca_pkg::ST_LOAD) || sw_go;
      unique case (st_r)
        eca_pkg::ST_STRAP: begin
          al_dis_r <= !strap_grant[0];
          st_r <= strap_grant[0] ? eca_pkg::ST_LOAD : eca_pkg::ST_READY;
        end
        eca_pkg::ST_LOAD: begin
          st_r <= eca_pkg::ST_WAIT;
        end
        eca_pkg::ST_WAIT: begin
          if (al_end) begin
            if (ser.ack_err || al_idx_r) begin
              st_r <= eca_pkg::ST_READY;
              al_ok_r <= al_good;
            end else begin
              ven_tmp_r <= ser.rdata;
              al_idx_r <= 1'b1;
              st_r <= eca_pkg::ST_LOAD;
            end
          end
        end
        eca_pkg::ST_READY: begin
          if (sw_go) begin
            st_r <= eca_pkg::ST_BUSY;
          end
        end
        eca_pkg::ST_BUSY: begin
          if (sw_end) begin
            st_r <= eca_pkg::ST_READY;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Identity registers keep their defaults unless both words load cleanly.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ven_r <= VEN_DEFAULT;
      prd_r <= PRD_DEFAULT;
    end else if (al_good) begin
      ven_r <= ven_tmp_r;
      prd_r <= ser.rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle control word.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_r <= 1'b0;
      cmd_r <= 1'b0;
      err_r <= 1'b0;
      rate_r <= eca_pkg::RATE_RST;
      addr_r <= 8'h00;
      data_r <= 16'h0000;
    end else if (wr_ctrl) begin
      start_r <= pwdata[eca_pkg::CTRL_START_BIT];
      cmd_r <= pwdata[eca_pkg::CTRL_CMD_BIT];
      rate_r <= pwdata[eca_pkg::CTRL_RATE_LSB +: 2];
      addr_r <= pwdata[eca_pkg::CTRL_ADDR_LSB +: 8];
      data_r <= pwdata[eca_pkg::CTRL_DATA_LSB +: 16];
    end else if (sw_end) begin
      start_r <= 1'b0;
      err_r <= ser.ack_err;
      if (!cmd_r) begin
        data_r <= ser.rdata;
      end
    end
  end

  assign ser.req = req_r;
  assign ser.cmd = al_mode ? 1'b0 : cmd_r;
  assign ser.addr = al_mode ? (al_idx_r ? eca_pkg::AL_PRD_ADDR
                                        : eca_pkg::AL_VEN_ADDR) : addr_r;
  assign ser.wdata = data_r;
  assign ser.lsb_first = lsb_r;
  // Autoload uses the strap speed; software cycles use the rate code.
  assign ser.fast = al_mode ? !slow_r : (rate_r == eca_pkg::RATE_FAST);

  eca_serial u_serial (
    .pclk(pclk),
    .presetn(presetn),
    .ser(ser.eng),
    .ee_data_i(ee_data_i),
    .ee_clk(ee_clk),
    .ee_data_o(ee_data_o),
    .ee_data_oe(ee_data_oe)
  );

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_start_holds: assert property (
    start_r && !sw_end |=> start_r)
    else $error("start flag fell before the cycle ended");

  a_start_clears: assert property (
    sw_end |=> !start_r && is_ready)
    else $error("start flag did not clear at the end of the cycle");

  a_cycle_issue: assert property (
    $rose(start_r) |-> req_r && ser.cmd == cmd_r && !al_mode)
    else $error("software cycle not issued with its command");

  a_addr_used: assert property (
    $rose(start_r) |-> ser.addr == addr_r && ser.wdata == data_r)
    else $error("software cycle uses the wrong address or data");

  a_err_update: assert property (
    sw_end |=> err_r == $past(ser.ack_err))
    else $error("error flag does not reflect the acknowledge");

  a_read_data: assert property (
    sw_end && !cmd_r |=> data_r == $past(ser.rdata) && !start_r)
    else $error("read word not stored when start cleared");

  a_al_success: assert property (
    $rose(al_ok_r) |-> $past(al_good) && rd_test[26])
    else $error("autoload success set without a good load");

  a_strap_latch: assert property (
    st_r == eca_pkg::ST_STRAP |=> lsb_r == $past(strap_grant[2])
      && slow_r == $past(strap_grant[1])
      && nobyp_r == $past(strap_grant[0]))
    else $error("straps not latched after reset");

  a_al_disable: assert property (
    is_ready |-> al_dis_r == !nobyp_r)
    else $error("autoload disable does not match the bypass strap");

  a_reserved_zero: assert property (
    apb_done && !pwrite && sel_test |-> prdata_r[31:30] == 2'b00
      && !prdata_r[25])
    else $error("reserved test bits not zero");

  a_ident_default: assert property (
    !al_ok_r |-> ven_r == VEN_DEFAULT && prd_r == PRD_DEFAULT)
    else $error("identity changed without a successful autoload");

  a_start_set: assert property (
    sw_go |=> start_r && is_busy)
    else $error("start flag not set by a software command");

  a_no_start_al: assert property (
    al_mode |-> !start_r)
    else $error("start flag set while autoload runs");

  a_err_hold: assert property (
    !sw_end |=> err_r == $past(err_r))
    else $error("error flag changed outside the end of a cycle");

  a_al_speed: assert property (
    req_r && is_wait |=> u_serial.div_r == (slow_r ? eca_pkg::DIV_SLOW
      : eca_pkg::DIV_FAST))
    else $error("autoload divisor does not follow the speed strap");

  a_load_select: assert property (
    st_r == eca_pkg::ST_STRAP |=> (nobyp_r ? st_r == eca_pkg::ST_LOAD
      : is_ready))
    else $error("autoload bypass strap not obeyed");

  a_al_mirror: assert property (
    apb_done && !pwrite && sel_test
      |-> prdata_r[eca_pkg::TEST_ALOK_BIT] == $past(al_ok_r))
    else $error("autoload status not mirrored in the test word");

  a_strap_read: assert property (
    apb_done && !pwrite && sel_test |-> prdata_r[29] == $past(lsb_r)
      && prdata_r[28] == $past(slow_r) && prdata_r[27] == $past(nobyp_r))
    else $error("strap bits not returned in the test word");

  a_data_hold: assert property (
    !wr_ctrl && !sw_end |=> data_r == $past(data_r))
    else $error("data field changed without a write or a read");

  a_addr_field: assert property (
    wr_ctrl |=> addr_r == $past(pwdata[eca_pkg::CTRL_ADDR_LSB +: 8]))
    else $error("address field not taken from bits 15 to 8");

  a_ident_hold: assert property (
    !al_good |=> ven_r == $past(ven_r) && prd_r == $past(prd_r))
    else $error("identity changed outside a successful autoload");

  c_sw_read: cover property (sw_end && !cmd_r && !ser.ack_err);
  c_sw_write: cover property (sw_end && cmd_r);
  c_al_good: cover property (al_good);
  c_ack_error: cover property (ser.done && ser.ack_err);

endmodule
`default_nettype wire

// ==== testbench/eca_eeprom_model.sv ====
// Behavioural serial EEPROM that answers read and write frames.
`timescale 1ns/100ps
`default_nettype none
module eca_eeprom_model (
  input wire logic ee_clk,
  input wire logic ee_data_o,
  input wire logic ee_data_oe,
  input wire logic lsb_first,
  input wire logic ack_en,
  output logic ee_data_i
);
  logic [15:0] mem [0:255];
  logic [25:0] bits;
  logic [7:0] a;
  logic [15:0] w;
  int cnt = 0;
  int rd = 99;
  initial ee_data_i = 1'b1;
  // A rising output enable opens a new frame.
  always @(posedge ee_data_oe) begin
    cnt = 0;
    rd = -1;
  end
  always @(posedge ee_clk) begin
    if (ee_data_oe && cnt < 26) begin
      bits[cnt] = ee_data_o;
      cnt++;
    end
  end
  // Answers change just after the clock fall, once the enable has settled.
  // A released line toggles so that no stale level can be mistaken for data.
  always @(negedge ee_clk) begin
    #1;
    if (!ee_data_oe && (cnt == 10 || cnt == 26) && rd < 0) begin
      for (int k = 0; k < 8; k++) a[k] = bits[lsb_first ? 2 + k : 9 - k];
      for (int k = 0; k < 16; k++) w[k] = bits[lsb_first ? 10 + k : 25 - k];
      if (ack_en && bits[1] && cnt == 26) mem[a] = w;
      ee_data_i = !ack_en;
      rd = (ack_en && !bits[1]) ? 0 : 99;
    end else if (rd >= 0 && rd < 16) begin
      ee_data_i = mem[a][lsb_first ? rd : 15 - rd];
      rd++;
    end else begin
      ee_data_i = !ee_data_i;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/eeprom_config_access_bench.sv ====
// Self-checking bench for the EEPROM configuration access block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); \
  end \
end
module eeprom_config_access_bench;
  // Identity defaults; the values are arbitrary.
  localparam logic [15:0] VEN = 16'h1357;
  localparam logic [15:0] PRD = 16'h2468;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [2:0] strap_grant = 3'h0;
  logic ack_en = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, ee_clk, ee_data_o, ee_data_oe, ee_data_i, irq;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  always #2.5 pclk = ~pclk;
  eca_top #(.VEN_DEFAULT(VEN), .PRD_DEFAULT(PRD)) u_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .strap_grant(strap_grant), .ee_data_i(ee_data_i),
    .ee_clk(ee_clk), .ee_data_o(ee_data_o), .ee_data_oe(ee_data_oe),
    .irq(irq));
  eca_eeprom_model u_ee (.ee_clk(ee_clk), .ee_data_o(ee_data_o),
    .ee_data_oe(ee_data_oe), .lsb_first(strap_grant[2]), .ack_en(ack_en),
    .ee_data_i(ee_data_i));
  task automatic stop_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 100000) begin
      failures++;
      stop_test();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic wait_idle(output logic [31:0] q);
    do rd(eca_pkg::ADDR_CTRL, q); while (q[0] !== 1'b0);
  endtask
  task automatic boot(input logic [2:0] s, input logic ack, input logic ok);
    logic [31:0] q;
    logic [31:0] x;
    int t0;
    x = {2'b00, s, ok, 1'b0, !s[0], 24'h00_0000};
    presetn <= 1'b0;
    strap_grant <= s;
    ack_en <= ack;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    if (s[0]) begin
      @(posedge ee_clk);
      t0 = cyc;
      @(posedge ee_clk);
      `CHK("al divisor", s[1] ? 256 : 128, cyc - t0)
      do rd(eca_pkg::ADDR_INT_STAT, q); while (q[2] !== 1'b1);
    end
    wr(eca_pkg::ADDR_TEST, 32'hffff_ffff);
    rd(eca_pkg::ADDR_TEST, q);
    `CHK("test", x, q)
    rd(eca_pkg::ADDR_CTRL, q);
    `CHK("ctrl", {4'h4, ok, 3'h0}, q[7:0])
    x = ok ? {u_ee.mem[1], u_ee.mem[0]} : {PRD, VEN};
    wr(eca_pkg::ADDR_IDENT, 32'hffff_ffff);
    rd(eca_pkg::ADDR_IDENT, q);
    `CHK("ident", x, q)
    $display("test boot done");
  endtask
  task automatic t_cycle(input logic c, input logic [7:0] a,
                         input logic [15:0] d, input logic [1:0] rate,
                         input int div);
    logic [31:0] q;
    int t0;
    wr(eca_pkg::ADDR_CTRL, {c ? d : ~d, a, rate, 4'h0, c, 1'b1});
    rd(eca_pkg::ADDR_CTRL, q);
    `CHK("start", 1'b1, q[0])
    // A second command while busy must leave the running one untouched.
    wr(eca_pkg::ADDR_CTRL, {16'h0000, ~a, rate, 4'h0, c, 1'b1});
    @(posedge ee_clk);
    t0 = cyc;
    @(posedge ee_clk);
    `CHK("divisor", div, cyc - t0)
    wait_idle(q);
    `CHK("addr", a, q[15:8])
    `CHK("cmd", c, q[1])
    `CHK("err", 1'b0, q[2])
    if (c) `CHK("wdata", d, u_ee.mem[a])
    else `CHK("rdata", d, q[31:16])
    $display("test cycle done");
  endtask
  task automatic t_err();
    logic [31:0] q;
    logic e;
    ack_en <= 1'b0;
    wr(eca_pkg::ADDR_INT_STAT, 32'h0000_0007);
    wr(eca_pkg::ADDR_CTRL, {16'h0000, 8'h11, 2'b01, 4'h0, 1'b0, 1'b1});
    wait_idle(q);
    `CHK("err", 1'b1, q[2])
    rd(eca_pkg::ADDR_INT_STAT, q);
    `CHK("stat", 1'b1, q[1])
    `CHK("stat done", 1'b1, q[0])
    `CHK("irq off", 1'b0, irq)
    wr(eca_pkg::ADDR_INT_MASK, 32'h0000_0002);
    rd(eca_pkg::ADDR_INT_MASK, q);
    `CHK("irq on", 1'b1, irq)
    wr(eca_pkg::ADDR_INT_STAT, 32'h0000_0002);
    rd(eca_pkg::ADDR_INT_STAT, q);
    `CHK("stat clr", 1'b0, q[1])
    `CHK("irq clr", 1'b0, irq)
    apb(1'b0, 8'h40, 32'h0000_0000, q, e);
    `CHK("slverr", 1'b1, e)
    `CHK("unmapped", 32'h0000_0000, q)
    ack_en <= 1'b1;
    $display("test error done");
  endtask
  initial begin
    u_ee.mem[0] = 16'h4c21;
    u_ee.mem[1] = 16'h93e5;
    boot(3'b101, 1'b1, 1'b1);
    t_cycle(1'b1, 8'h5a, 16'hbeef, 2'b10, 128);
    t_cycle(1'b0, 8'h01, 16'h93e5, 2'b01, 256);
    t_err();
    boot(3'b010, 1'b1, 1'b0);
    t_cycle(1'b1, 8'h3c, 16'h1234, 2'b10, 128);
    boot(3'b011, 1'b0, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
